// >>> hw/pwr_pkg.sv
package pwr_pkg;
   localparam logic [7:0] CMD_PARTIAL = 8'hD3;
   localparam logic [7:0] CMD_IDLE = 8'hD4;
   localparam logic [7:0] CMD_NV_DATA = 8'hE0;
   localparam logic [7:0] CMD_NV_CTRL = 8'hE1;
   localparam logic [7:0] CMD_NV_STAT = 8'hE2;
   localparam logic [7:0] CMD_NV_KEY = 8'hE3;
   localparam logic [15:0] KEY_UNLOCK = 16'hAA55;
   localparam logic [15:0] KEY_RESET = 16'h0000;
   localparam logic [2:0] AMP_RESET = 3'h1;
   localparam logic [2:0] DIV_RESET = 3'h2;
   localparam logic [2:0] AMP_HALT = 3'h0;
   localparam logic [2:0] DIV_HALT = 3'h7;
   localparam logic [2:0] P2_INHIBIT = 3'h6;
   localparam logic [7:0] NV_RESET = 8'h00;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [1:0] CNT_RESET = 2'h0;
   localparam logic [1:0] CNT_STEP = 2'h1;
   localparam int AMP_LSB = 0;
   localparam int P1_LSB = 0;
   localparam int P2_LSB = 4;
   localparam int ID_EN_BIT = 5;
   localparam int LV_EN_BIT = 4;
   localparam int SEL_LSB = 0;
   localparam int LV_MARK_BIT = 7;
   localparam int LV_LSB = 0;
   localparam logic [1:0] IDX_FIRST = 2'h0;
   localparam logic [1:0] IDX_SECOND = 2'h1;
   localparam logic [1:0] IDX_THIRD = 2'h2;
   localparam logic [9:0] DIV_ONE = 10'h001;
   localparam logic [9:0] DIV_P2_BASE = 10'h010;

   typedef struct packed {
      logic [2:0] ampCurrent;
      logic [2:0] pump2Divider;
      logic [2:0] pump1Divider;
   } pwr_mode_t;

   typedef struct packed {
      logic identProgramEnable;
      logic levelProgramEnable;
      logic [1:0] identByteSelect;
   } pwr_nvctl_t;

   typedef enum logic [1:0] {
      CM_NONE = 2'b00,
      CM_LEVEL = 2'b01,
      CM_IDENT = 2'b10
   } pwr_prog_t;

   // amplifier ratio in quarters: {gamma, source}
   function automatic logic [5:0] pwr_amp_ratio(input logic [2:0] code);
      case (code)
         3'h1: pwr_amp_ratio = {3'h4, 3'h4};
         3'h2: pwr_amp_ratio = {3'h4, 3'h3};
         3'h3: pwr_amp_ratio = {3'h4, 3'h2};
         3'h4: pwr_amp_ratio = {3'h3, 3'h4};
         3'h5: pwr_amp_ratio = {3'h3, 3'h3};
         3'h6: pwr_amp_ratio = {3'h3, 3'h2};
         3'h7: pwr_amp_ratio = {3'h2, 3'h2};
         default: pwr_amp_ratio = {3'h0, 3'h0};
      endcase
   endfunction : pwr_amp_ratio
endpackage : pwr_pkg

// >>> hw/pwr_byte_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module pwr_byte_decoder
   import pwr_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // async reset
   input wire logic dataCommandSelect, // 0 command, 1 parameter
   input wire logic writeStrobe, // write strobe, sampled
   input wire logic readStrobe, // read strobe, high when idle
   input wire logic [7:0] busData, // data bus
   output logic byteValid, // one-cycle pulse per byte
   output logic isParam, // byte is a parameter
   output logic [7:0] byteData, // latched byte
   output logic [7:0] curCommand, // last command
   output logic [1:0] paramIndex // index of this parameter
);
   logic strobe_q;
   logic [1:0] cnt_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_q <= 1'b1;
      end else begin
         strobe_q <= writeStrobe;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         byteValid <= 1'b0;
         isParam <= 1'b0;
         byteData <= NV_RESET;
         curCommand <= NV_RESET;
         paramIndex <= IDX_FIRST;
         cnt_q <= IDX_FIRST;
      end else begin
         byteValid <= 1'b0;
         if (writeStrobe && !strobe_q && readStrobe) begin
            byteValid <= 1'b1;
            isParam <= dataCommandSelect;
            byteData <= busData;
            if (!dataCommandSelect) begin
               curCommand <= busData;
               cnt_q <= IDX_FIRST;
            end else begin
               paramIndex <= cnt_q;
               if (cnt_q != IDX_THIRD) begin
                  cnt_q <= cnt_q + CNT_STEP;
               end
            end
         end
      end
   end

   edge_a: assert property (@(posedge clk) disable iff (rst)
      writeStrobe && !strobe_q && readStrobe |=> byteValid)
      else $error("write strobe edge not latched");
endmodule : pwr_byte_decoder
`default_nettype wire

// >>> hw/pwr_pump_divider.sv
`timescale 1ns/100ps
`default_nettype none
module pwr_pump_divider
   import pwr_pkg::*;
(
   input wire logic clk, // clock, stands for the oscillator
   input wire logic rst, // async reset
   input wire logic isPump2, // 1 selects pump-2 table
   input wire logic [2:0] code, // divider code
   output logic pumpClock, // divided clock
   output logic halted // pump stopped
);
   logic [9:0] cnt_q;
   logic [9:0] ratio;
   logic stop;

   always_comb begin
      ratio = (isPump2 ? DIV_P2_BASE : DIV_ONE) << code;
      stop = (code == DIV_HALT) || (isPump2 && code == P2_INHIBIT);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 10'h000;
         pumpClock <= 1'b0;
         halted <= 1'b0;
      end else begin
         halted <= stop;
         if (stop) begin
            cnt_q <= 10'h000;
            pumpClock <= 1'b0;
         end else if (cnt_q >= ratio - DIV_ONE) begin
            cnt_q <= 10'h000;
            pumpClock <= 1'b1;
         end else begin
            cnt_q <= cnt_q + DIV_ONE;
            pumpClock <= 1'b0;
         end
      end
   end

   halt_pump_a: assert property (@(posedge clk) disable iff (rst)
      code == DIV_HALT |=> halted && !pumpClock)
      else $error("pump not halted");
endmodule : pwr_pump_divider
`default_nettype wire

// >>> hw/pwr_mode_regs.sv
`timescale 1ns/100ps
`default_nettype none
module pwr_mode_regs
   import pwr_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // hardware reset
   input wire logic dataCommandSelect, // 0 command, 1 parameter
   input wire logic writeStrobe, // write strobe
   input wire logic readStrobe, // read strobe
   input wire logic [7:0] busData, // data bus
   input wire logic partialActive, // partial display mode on
   input wire logic idleActive, // idle mode on
   output logic [2:0] ampCurrent, // applied amplifier current code
   output logic [5:0] ampRatio, // gamma and source ratio in quarters
   output logic ampHalt, // amplifier and step-up halted
   output logic pump1Clock, // step-up 1 clock
   output logic pump2Clock, // step-up 2 clock
   output pwr_mode_t partialSetting, // partial-mode fields
   output pwr_mode_t idleSetting, // idle-mode fields
   output logic [7:0] nonvolatileWriteByte, // data to program
   output pwr_nvctl_t nvControl, // programming control
   output logic programPulse, // one-cycle program strobe
   output logic [1:0] programTarget, // 1 level, 2 ident
   output logic [5:0] storedLevelValue, // programmed level
   output logic [1:0] programmedCount, // level program count
   output logic [7:0] readData, // status read byte
   output logic readDataValid // status byte presented
);
   logic byteValid;
   logic isParam;
   logic [7:0] byteData;
   logic [7:0] curCommand;
   logic [1:0] paramIndex;
   logic [15:0] key_q;
   logic [31:0] ident_q;
   logic rdStrobe_q;
   logic [1:0] rdIdx_q;
   pwr_mode_t active;
   pwr_prog_t progMode;
   logic p1Clk;
   logic p2Clk;
   logic p1Halt;
   logic p2Halt;

   pwr_byte_decoder u_dec (
      .clk(clk),
      .rst(rst),
      .dataCommandSelect(dataCommandSelect),
      .writeStrobe(writeStrobe),
      .readStrobe(readStrobe),
      .busData(busData),
      .byteValid(byteValid),
      .isParam(isParam),
      .byteData(byteData),
      .curCommand(curCommand),
      .paramIndex(paramIndex)
   );

   wire logic paramWr = byteValid && isParam;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         partialSetting <= '{AMP_RESET, DIV_RESET, DIV_RESET};
      end else if (paramWr && curCommand == CMD_PARTIAL) begin
         if (paramIndex == IDX_FIRST) begin
            partialSetting.ampCurrent <= byteData[AMP_LSB +: 3];
         end else if (paramIndex == IDX_SECOND) begin
            partialSetting.pump2Divider <= byteData[P2_LSB +: 3];
            partialSetting.pump1Divider <= byteData[P1_LSB +: 3];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idleSetting <= '{AMP_RESET, DIV_RESET, DIV_RESET};
      end else if (paramWr && curCommand == CMD_IDLE) begin
         if (paramIndex == IDX_FIRST) begin
            idleSetting.ampCurrent <= byteData[AMP_LSB +: 3];
         end else if (paramIndex == IDX_SECOND) begin
            idleSetting.pump2Divider <= byteData[P2_LSB +: 3];
            idleSetting.pump1Divider <= byteData[P1_LSB +: 3];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nonvolatileWriteByte <= NV_RESET;
      end else if (paramWr && curCommand == CMD_NV_DATA && paramIndex == IDX_FIRST) begin
         nonvolatileWriteByte <= byteData;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nvControl <= '{1'b0, 1'b0, SEL_RESET};
      end else if (paramWr && curCommand == CMD_NV_CTRL && paramIndex == IDX_FIRST) begin
         nvControl.identProgramEnable <= byteData[ID_EN_BIT];
         nvControl.levelProgramEnable <= byteData[LV_EN_BIT];
         nvControl.identByteSelect <= byteData[SEL_LSB +: 2];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         key_q <= KEY_RESET;
      end else if (paramWr && curCommand == CMD_NV_KEY) begin
         if (paramIndex == IDX_FIRST) begin
            key_q[15:8] <= byteData;
         end else if (paramIndex == IDX_SECOND) begin
            key_q[7:0] <= byteData;
         end
      end
   end

   always_comb begin
      case ({nvControl.identProgramEnable, nvControl.levelProgramEnable})
         2'b01: progMode = CM_LEVEL;
         2'b10: progMode = CM_IDENT;
         default: progMode = CM_NONE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         programPulse <= 1'b0;
         programTarget <= CM_NONE;
      end else begin
         programPulse <= 1'b0;
         if (paramWr && curCommand == CMD_NV_DATA && paramIndex == IDX_FIRST
               && key_q == KEY_UNLOCK && progMode != CM_NONE) begin
            programPulse <= 1'b1;
            programTarget <= progMode;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         storedLevelValue <= 6'h00;
         programmedCount <= CNT_RESET;
      end else if (programPulse && programTarget == CM_LEVEL) begin
         storedLevelValue <= nonvolatileWriteByte[LV_LSB +: 6];
         programmedCount <= programmedCount + CNT_STEP;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ident_q <= 32'h0000_0000;
      end else if (programPulse && programTarget == CM_IDENT) begin
         case (nvControl.identByteSelect)
            2'h0: ident_q[31:24] <= nonvolatileWriteByte;
            2'h1: ident_q[23:16] <= nonvolatileWriteByte;
            2'h2: ident_q[15:8] <= nonvolatileWriteByte;
            default: ident_q[7:0] <= nonvolatileWriteByte;
         endcase
      end
   end

   // status read: dummy, count, level on successive read strobes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdStrobe_q <= 1'b1;
         rdIdx_q <= IDX_FIRST;
         readData <= NV_RESET;
         readDataValid <= 1'b0;
      end else begin
         rdStrobe_q <= readStrobe;
         readDataValid <= 1'b0;
         if (byteValid && !isParam) begin
            rdIdx_q <= IDX_FIRST;
         end else if (readStrobe && !rdStrobe_q && dataCommandSelect
               && curCommand == CMD_NV_STAT) begin
            readDataValid <= 1'b1;
            case (rdIdx_q)
               IDX_SECOND: readData <= {6'h00, programmedCount};
               IDX_THIRD: readData <= {2'h0, storedLevelValue};
               default: readData <= NV_RESET;
            endcase
            if (rdIdx_q != IDX_THIRD) begin
               rdIdx_q <= rdIdx_q + CNT_STEP;
            end
         end
      end
   end

   always_comb begin
      if (partialActive) begin
         active = partialSetting;
      end else if (idleActive) begin
         active = idleSetting;
      end else begin
         active = partialSetting;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ampCurrent <= AMP_RESET;
         ampRatio <= 6'h00;
         ampHalt <= 1'b0;
      end else begin
         ampCurrent <= active.ampCurrent;
         ampRatio <= pwr_amp_ratio(active.ampCurrent);
         ampHalt <= active.ampCurrent == AMP_HALT;
      end
   end

   pwr_pump_divider u_p1 (
      .clk(clk),
      .rst(rst),
      .isPump2(1'b0),
      .code(active.pump1Divider),
      .pumpClock(p1Clk),
      .halted(p1Halt)
   );

   pwr_pump_divider u_p2 (
      .clk(clk),
      .rst(rst),
      .isPump2(1'b1),
      .code(active.pump2Divider),
      .pumpClock(p2Clk),
      .halted(p2Halt)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pump1Clock <= 1'b0;
         pump2Clock <= 1'b0;
      end else begin
         pump1Clock <= p1Clk && !p1Halt && !ampHalt;
         pump2Clock <= p2Clk && !p2Halt && !ampHalt;
      end
   end

   partial_write_a: assert property (@(posedge clk) disable iff (rst)
      paramWr && curCommand == CMD_PARTIAL && paramIndex == IDX_SECOND
      |=> partialSetting.pump2Divider == $past(byteData[6:4]))
      else $error("partial pump-2 not stored");
   idle_write_a: assert property (@(posedge clk) disable iff (rst)
      paramWr && curCommand == CMD_IDLE && paramIndex == IDX_FIRST
      |=> idleSetting.ampCurrent == $past(byteData[2:0]))
      else $error("idle amp not stored");
   amp_halt_a: assert property (@(posedge clk) disable iff (rst)
      ampHalt |-> ##1 !pump1Clock && !pump2Clock)
      else $error("pump runs while amplifier halted");
   amp_zero_a: assert property (@(posedge clk) disable iff (rst)
      ampCurrent == AMP_HALT |-> ampHalt && ampRatio == 6'h00)
      else $error("amplifier code zero not halted");
   amp_ratio_a: assert property (@(posedge clk) disable iff (rst)
      ampCurrent == 3'h7 |-> ampRatio == 6'h12)
      else $error("half ratio not applied");
   nv_data_a: assert property (@(posedge clk) disable iff (rst)
      paramWr && curCommand == CMD_NV_DATA && paramIndex == IDX_FIRST
      |=> nonvolatileWriteByte == $past(byteData))
      else $error("data byte not stored");
   pulse_once_a: assert property (@(posedge clk) disable iff (rst)
      programPulse |=> !programPulse)
      else $error("program strobe longer than one cycle");
   both_enable_a: assert property (@(posedge clk) disable iff (rst)
      programPulse |-> programTarget != CM_NONE
      && !(nvControl.identProgramEnable && nvControl.levelProgramEnable))
      else $error("programming with bad enables");
   key_lock_a: assert property (@(posedge clk) disable iff (rst)
      key_q != KEY_UNLOCK ##1 key_q == $past(key_q) |-> !programPulse)
      else $error("programmed while locked");
   key_write_a: assert property (@(posedge clk) disable iff (rst)
      paramWr && curCommand == CMD_NV_KEY && paramIndex == IDX_SECOND
      |=> key_q[7:0] == $past(byteData))
      else $error("key low byte not stored");
   count_step_a: assert property (@(posedge clk) disable iff (rst)
      programPulse && programTarget == CM_LEVEL
      |=> programmedCount == $past(programmedCount) + CNT_STEP)
      else $error("count not advanced");
   ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
      paramWr && curCommand == CMD_NV_CTRL && paramIndex == IDX_FIRST
      |=> nvControl.identByteSelect == $past(byteData[1:0]))
      else $error("select not stored");
   ident_sel_a: assert property (@(posedge clk) disable iff (rst)
      programPulse && programTarget == CM_IDENT && nvControl.identByteSelect == IDX_SECOND
      |=> ident_q[23:16] == $past(nonvolatileWriteByte))
      else $error("ident byte not stored");

   level_prog_c: cover property (@(posedge clk) programPulse && programTarget == CM_LEVEL);
   ident_prog_c: cover property (@(posedge clk) programPulse && programTarget == CM_IDENT);
   partial_set_c: cover property (@(posedge clk) paramWr && curCommand == CMD_PARTIAL);
   status_rd_c: cover property (@(posedge clk) readDataValid);
   refused_prog_c: cover property (@(posedge clk)
      paramWr && curCommand == CMD_NV_DATA && progMode == CM_NONE);
endmodule : pwr_mode_regs
`default_nettype wire

// >>> verification/pwr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pwr_host_model
   import pwr_pkg::*;
(
   input wire logic clk, // clock
   input wire logic [7:0] readData, // status byte from device
   input wire logic readDataValid, // status byte presented
   output logic dataCommandSelect, // 0 command, 1 parameter
   output logic writeStrobe, // write strobe
   output logic readStrobe, // read strobe
   output logic [7:0] busData // data bus
);
   initial begin
      dataCommandSelect = 1'b1;
      writeStrobe = 1'b1;
      readStrobe = 1'b1;
      busData = 8'h00;
   end

   task automatic putByte(input logic isParam, input logic [7:0] value);
      @(posedge clk);
      #1;
      dataCommandSelect = isParam;
      busData = value;
      writeStrobe = 1'b0;
      @(posedge clk);
      #1;
      writeStrobe = 1'b1;
      @(posedge clk);
      #1;
      // bus has no pull, so a released bus must not keep the old byte
      busData = ~value;
   endtask : putByte

   task automatic getByte(output logic [7:0] value, output logic seen);
      int n;
      @(posedge clk);
      #1;
      dataCommandSelect = 1'b1;
      readStrobe = 1'b0;
      @(posedge clk);
      #1;
      readStrobe = 1'b1;
      value = 8'h00;
      seen = 1'b0;
      for (n = 0; n < 8 && !seen; n++) begin
         @(posedge clk);
         #1;
         if (readDataValid === 1'b1) begin
            value = readData;
            seen = 1'b1;
         end
      end
   endtask : getByte
endmodule : pwr_host_model
`default_nettype wire

// >>> verification/power_mode_and_otp_program_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module power_mode_and_otp_program_regs_tb
   import pwr_pkg::*;
;
   logic clk, rst, partialActive, idleActive;
   logic dataCommandSelect, writeStrobe, readStrobe;
   logic [7:0] busData, nonvolatileWriteByte, readData, rd;
   logic [2:0] ampCurrent;
   logic [5:0] ampRatio, storedLevelValue;
   logic ampHalt, pump1Clock, pump2Clock, programPulse, readDataValid, ok;
   pwr_mode_t partialSetting, idleSetting;
   pwr_nvctl_t nvControl;
   logic [1:0] programTarget, programmedCount;
   logic [15:0] per;
   logic [5:0] ratioTbl [8] = '{6'h00, 6'h24, 6'h23, 6'h22, 6'h1C, 6'h1B, 6'h1A, 6'h12};
   int badCount = 0;
   int numChecks = 0;
   int pulses = 0;
   int i, c2;

   pwr_mode_regs dut (.clk, .rst, .dataCommandSelect, .writeStrobe, .readStrobe, .busData,
      .partialActive, .idleActive, .ampCurrent, .ampRatio, .ampHalt, .pump1Clock,
      .pump2Clock, .partialSetting, .idleSetting, .nonvolatileWriteByte, .nvControl,
      .programPulse, .programTarget, .storedLevelValue, .programmedCount, .readData,
      .readDataValid);

   pwr_host_model host (.clk, .readData, .readDataValid, .dataCommandSelect, .writeStrobe,
      .readStrobe, .busData);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      if (programPulse === 1'b1) begin
         pulses++;
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      numChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d, mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   task automatic wr(input logic [7:0] cmd, input int n, input logic [7:0] a,
         input logic [7:0] b);
      host.putByte(1'b0, cmd);
      if (n > 0) host.putByte(1'b1, a);
      if (n > 1) host.putByte(1'b1, b);
      repeat (6) @(posedge clk);
      #1;
   endtask : wr

   // period between the second and third pump pulse, 0 if too few
   task automatic measure(input logic sel, output logic [15:0] p);
      int k;
      int hits;
      int last;
      p = 16'h0000;
      hits = 0;
      last = 0;
      for (k = 0; k < 2100; k++) begin
         @(posedge clk);
         if ((sel ? pump2Clock : pump1Clock) === 1'b1) begin
            hits++;
            if (hits == 3) p = 16'(k - last);
            last = k;
         end
      end
   endtask : measure

   task automatic checkDefaults;
      chk("partialSetting", 16'h0052, {7'h00, partialSetting});
      chk("idleSetting", 16'h0052, {7'h00, idleSetting});
      chk("ampCurrent", 16'h0001, {13'h0000, ampCurrent});
      chk("writeByte", 16'h0000, {8'h00, nonvolatileWriteByte});
      chk("nvControl", 16'h0000, {12'h000, nvControl});
      chk("programmedCount", 16'h0000, {14'h0000, programmedCount});
   endtask : checkDefaults

   initial begin
      repeat (80000) @(posedge clk);
      badCount++;
      results();
   end

   initial begin
      rst = 1'b1;
      partialActive = 1'b0;
      idleActive = 1'b0;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      checkDefaults();
      partialActive = 1'b1;
      for (i = 0; i < 8; i++) begin
         wr(CMD_PARTIAL, 2, 8'(i), 8'h22);
         chk("ampCurrent", 16'(i), {13'h0000, ampCurrent});
         chk("ampRatio", {10'h000, ratioTbl[i]}, {10'h000, ampRatio});
         chk("ampHalt", {15'h0000, i == 0}, {15'h0000, ampHalt});
      end
      partialActive = 1'b0;
      for (i = 0; i < 8; i++) begin
         c2 = (i == 6) ? 7 : i; // pump-2 code six never sent
         wr(CMD_PARTIAL, 2, 8'h01, 8'(c2 * 16 + i));
         chk("partialSetting", 16'(64 + c2 * 8 + i), {7'h00, partialSetting});
         measure(1'b0, per);
         chk("pump1Period", (i == 7) ? 16'h0000 : 16'(1 << i), per);
         measure(1'b1, per);
         chk("pump2Period", (c2 == 7) ? 16'h0000 : 16'(16 << c2), per);
      end
      wr(CMD_PARTIAL, 2, 8'h00, 8'h00);
      measure(1'b0, per);
      chk("haltedPump1", 16'h0000, per);
      measure(1'b1, per);
      chk("haltedPump2", 16'h0000, per);
      idleActive = 1'b1;
      wr(CMD_IDLE, 2, 8'h05, 8'h13);
      chk("idleSetting", 16'h014B, {7'h00, idleSetting});
      chk("ampCurrent", 16'h0005, {13'h0000, ampCurrent});
      host.putByte(1'b1, 8'h77);
      wr(CMD_IDLE, 0, 8'h00, 8'h00);
      chk("idleSetting", 16'h014B, {7'h00, idleSetting});
      partialActive = 1'b1;
      wr(CMD_IDLE, 2, 8'h06, 8'h54);
      chk("idleSetting", 16'h01AC, {7'h00, idleSetting});
      chk("ampCurrent", 16'h0000, {13'h0000, ampCurrent});
      partialActive = 1'b0;
      idleActive = 1'b0;
      wr(CMD_NV_KEY, 2, 8'hAA, 8'h55);
      wr(CMD_NV_CTRL, 1, 8'h10, 8'h00);
      chk("nvControl", 16'h0004, {12'h000, nvControl});
      wr(CMD_NV_DATA, 1, 8'h9F, 8'h00);
      chk("writeByte", 16'h009F, {8'h00, nonvolatileWriteByte});
      chk("programPulses", 16'h0001, 16'(pulses));
      chk("programTarget", 16'h0001, {14'h0000, programTarget});
      chk("storedLevel", 16'h001F, {10'h000, storedLevelValue});
      chk("programmedCount", 16'h0001, {14'h0000, programmedCount});
      host.putByte(1'b0, CMD_NV_STAT);
      host.getByte(rd, ok);
      host.getByte(rd, ok);
      chk("statusCount", 16'h0101, {7'h00, ok, rd});
      host.getByte(rd, ok);
      chk("statusLevel", 16'h011F, {7'h00, ok, rd});
      wr(CMD_NV_CTRL, 1, 8'h30, 8'h00);
      wr(CMD_NV_DATA, 1, 8'h85, 8'h00);
      wr(CMD_NV_CTRL, 1, 8'h00, 8'h00);
      wr(CMD_NV_DATA, 1, 8'h86, 8'h00);
      chk("programPulses", 16'h0001, 16'(pulses));
      chk("programmedCount", 16'h0001, {14'h0000, programmedCount});
      for (i = 0; i < 4; i++) begin
         wr(CMD_NV_CTRL, 1, 8'(8'h20 + i), 8'h00);
         chk("nvControl", 16'(8 + i), {12'h000, nvControl});
         wr(CMD_NV_DATA, 1, 8'(8'h40 + i), 8'h00);
         chk("programPulses", 16'(2 + i), 16'(pulses));
         chk("programTarget", 16'h0002, {14'h0000, programTarget});
      end
      wr(CMD_NV_CTRL, 1, 8'h10, 8'h00);
      wr(CMD_NV_DATA, 1, 8'hA5, 8'h00);
      chk("programmedCount", 16'h0002, {14'h0000, programmedCount});
      chk("storedLevel", 16'h0025, {10'h000, storedLevelValue});
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      checkDefaults();
      wr(CMD_NV_CTRL, 1, 8'h10, 8'h00);
      wr(CMD_NV_DATA, 1, 8'h9F, 8'h00);
      chk("programPulses", 16'h0006, 16'(pulses));
      chk("programmedCount", 16'h0000, {14'h0000, programmedCount});
      results();
   end
endmodule : power_mode_and_otp_program_regs_tb
`default_nettype wire
